// >>> design/fre_flash_row_erase_control.sv
// Row erase sequencer with its Wishbone register file
//
// The Wishbone slave port and the register offsets were decided locally.
`default_nettype none
module fre_flash_row_erase_control #(
   parameter int unsigned ERASE_CYC = fre_pkg::ERASE_CYCLES
) (
   // Clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        RST_B_IN,
   input  wire logic        POR_IN,
   // Wishbone slave
   input  wire logic        WB_CYC_IN,
   input  wire logic        WB_STB_IN,
   input  wire logic        WB_WE_IN,
   input  wire logic [3:0]  WB_SEL_IN,
   input  wire logic [5:0]  WB_ADR_IN,
   input  wire logic [31:0] WB_DAT_IN,
   output logic      [31:0] WB_DAT_OUT,
   output logic             WB_ACK_OUT,
   // Core and flash array
   output logic             CORE_STALL_OUT,
   output logic             ERASE_BUSY_OUT,
   output logic      [14:0] ERASE_ROW_ADDR_OUT
);
   import fre_pkg::*;

   // All state of the block
   typedef struct packed {
      fre_state_e  st;
      fre_key_e    key;
      logic [31:0] cnt;
      logic [7:0]  dat_lo;
      logic [7:0]  dat_hi;
      logic [7:0]  adr_lo;
      logic [7:0]  adr_hi;
      logic [7:0]  ctrl;
      logic        ack;
      logic [31:0] rdat;
      logic [14:0] row;
   } fre_state_s;

   fre_state_s s_q;   // Registered state
   fre_state_s s_d;   // Next state

   logic       wr_stb;   // Write taken this cycle
   logic       rd_stb;   // Read taken this cycle
   logic [3:0] idx;      // Word index
   logic [7:0] wb;       // Written byte

   // Read mux, decoding shared by bus read path
   function automatic logic [7:0] rd_byte(input fre_state_s s,
                                          input logic [3:0] i);
      case (i)
         OFS_DATA_LOW:  rd_byte = s.dat_lo;                  // [R12]
         OFS_DATA_HIGH: rd_byte = s.dat_hi & DATA_HIGH_MASK; // [R13] [R14]
         OFS_ADDR_LOW:  rd_byte = s.adr_lo;                  // [R15]
         OFS_ADDR_HIGH: rd_byte = (s.adr_hi & ADDR_HIGH_MASK) | ADDR_HIGH_RD1;
         OFS_CTRL_ONE:  rd_byte = s.ctrl | CTRL_RD1;
         default:       rd_byte = ZERO8;  // Key and unmapped read zero
      endcase
   endfunction

   // Bus decode; ack one cycle after the strobe, dropped the next
   always_comb begin
      idx    = WB_ADR_IN[5:2];
      wb     = WB_DAT_IN[7:0];
      wr_stb = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !s_q.ack && WB_SEL_IN[0];
      rd_stb = WB_CYC_IN && WB_STB_IN && !WB_WE_IN && !s_q.ack;
   end

   // Next state
   always_comb begin
      s_d     = s_q;
      s_d.ack = WB_CYC_IN && WB_STB_IN && !s_q.ack;
      if (rd_stb) begin
         s_d.rdat = {24'h00_0000, rd_byte(s_q, idx)};
      end
      // Register writes; taken in every state, so bus writes also land during erase
      if (wr_stb) begin
         case (idx)
            OFS_DATA_LOW:  s_d.dat_lo = wb;                   // [R12]
            OFS_DATA_HIGH: s_d.dat_hi = wb & DATA_HIGH_MASK;  // [R13] [R14]
            OFS_ADDR_LOW:  s_d.adr_lo = wb;                   // [R15]
            OFS_ADDR_HIGH: s_d.adr_hi = wb & ADDR_HIGH_MASK;
            OFS_CTRL_ONE: begin
               s_d.ctrl = (wb & CTRL_WMASK) | (s_q.ctrl & ~CTRL_WMASK);
            end
            default: begin
            end
         endcase
      end
      // Unlock key tracking: only two consecutive key writes open it
      if (wr_stb) begin
         if (idx == OFS_KEY) begin
            if (s_q.key == KEY_NONE && wb == KEY_FIRST) begin
               s_d.key = KEY_HALF;                            // [R5]
            end else if (s_q.key == KEY_HALF && wb == KEY_SECOND) begin
               s_d.key = KEY_OPEN;                            // [R5]
            end else begin
               s_d.key = KEY_NONE;
            end
         end else if (!(idx == OFS_CTRL_ONE && s_q.key == KEY_OPEN)) begin
            s_d.key = KEY_NONE;  // Any other write breaks the key, except a control one write with the key open
         end
      end
      // Sequencer
      case (s_q.st)
         ST_IDLE: begin
            // Start accepted only with key open, erase and write enabled
            if (wr_stb && idx == OFS_CTRL_ONE && wb[BIT_START]
                && s_q.key == KEY_OPEN) begin
               s_d.key = KEY_NONE;
               if (wb[BIT_FREE] && wb[BIT_PROGRAM_WRITE_ENABLE] && !wb[BIT_CONFIG_SPACE_SELECT]) begin
                  s_d.ctrl[BIT_START] = 1'b1;                 // [R6]
                  s_d.st  = ST_SETUP;
                  s_d.cnt = 32'(SETUP_CYCLES - 1);            // [R7]
                  // Whole row, word bits inside the row dropped
                  s_d.row = {s_q.adr_hi[6:0], s_q.adr_lo} & ROW_MASK; // [R1]
               end
            end
         end
         ST_SETUP: begin
            if (s_q.cnt == ZERO32) begin
               s_d.st  = ST_ERASE;
               s_d.cnt = 32'(ERASE_CYC - 1);                  // [R9]
            end else begin
               s_d.cnt = s_q.cnt - 32'd1;                     // [R7]
            end
         end
         ST_ERASE: begin
            if (s_q.cnt == ZERO32) begin
               s_d.st = ST_IDLE;                              // [R11]
               s_d.ctrl[BIT_START] = 1'b0;                    // [R17]
            end else begin
               s_d.cnt = s_q.cnt - 32'd1;                     // [R9]
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   // State register; data bytes only clear on power-on reset
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         s_q.st   <= ST_IDLE;
         s_q.key  <= KEY_NONE;
         s_q.cnt  <= ZERO32;
         s_q.adr_lo <= ZERO8;                                 // [R16]
         s_q.adr_hi <= ZERO8;
         s_q.ctrl <= ZERO8;
         s_q.ack  <= 1'b0;
         s_q.rdat <= ZERO32;
         s_q.row  <= 15'h0000;
         // Warm reset keeps data; power-on loses it
         if (POR_IN) begin
            s_q.dat_lo <= ZERO8;                              // [R16]
            s_q.dat_hi <= ZERO8;
         end else begin
            s_q.dat_lo <= s_q.dat_lo;
            s_q.dat_hi <= s_q.dat_hi;
         end
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs; stall holds only the core, clock keeps running
   always_comb begin
      WB_DAT_OUT         = s_q.rdat;
      WB_ACK_OUT         = s_q.ack;
      CORE_STALL_OUT     = (s_q.st == ST_ERASE);              // [R10]
      ERASE_BUSY_OUT     = (s_q.st != ST_IDLE);
      ERASE_ROW_ADDR_OUT = s_q.row;
   end
endmodule
`default_nettype wire

// >>> design/fre_pkg.sv
// Package: register map, field layout and timing for the row erase control
// Functional notes
// [R1] Erase acts on whole rows only
// [R2] Software loads any address inside the row
// [R3] Software clears config space select first
// [R4] Software sets row erase and write enable
// [R5] Unlock key 55h then AAh, consecutive writes
// [R6] Start bit begins the row erase
// [R7] Two setup cycles before execution halts
// [R8] Software places two no-ops after start
// [R9] Execution halts for the erase time
// [R10] Clocks and peripherals keep running meanwhile
// [R11] Resume at third instruction after start
// [R12] Data low is eight read/write bits
// [R13] Data high holds six read/write bits
// [R14] Data high bits 7-6 read zero
// [R15] Address low is eight read/write bits
// [R16] Address low resets; data survives warm resets
// [R17] Start bit self-clears when erase completes
`default_nettype none
package fre_pkg;
   // Word offsets of the registers (byte address = 4 * index)
   localparam logic [3:0] OFS_DATA_LOW  = 4'h0;
   localparam logic [3:0] OFS_DATA_HIGH = 4'h1;
   localparam logic [3:0] OFS_ADDR_LOW  = 4'h2;
   localparam logic [3:0] OFS_ADDR_HIGH = 4'h3;
   localparam logic [3:0] OFS_CTRL_ONE  = 4'h4;
   localparam logic [3:0] OFS_KEY       = 4'h5;
   // Control one field positions
   localparam int BIT_START  = 1;
   localparam int BIT_PROGRAM_WRITE_ENABLE   = 2;
   localparam int BIT_FREE   = 4;
   localparam int BIT_CONFIG_SPACE_SELECT   = 6;
   // Masks and resets
   localparam logic [7:0] DATA_HIGH_MASK = 8'h3F;
   localparam logic [7:0] ADDR_HIGH_MASK = 8'h7F;
   localparam logic [7:0] ADDR_HIGH_RD1  = 8'h80;
   localparam logic [7:0] CTRL_RD1       = 8'h80;
   localparam logic [7:0] CTRL_WMASK     = 8'h54;
   localparam logic [7:0] ZERO8          = 8'h00;
   localparam logic [31:0] ZERO32        = 32'h0000_0000;
   // Row mask for 32-word rows, low five address bits cleared
   localparam logic [14:0] ROW_MASK = 15'h7FE0;
   // Unlock key bytes
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // Timing
   localparam int CLK_MHZ       = 200;
   localparam int ERASE_TIME_US = 2000;
   localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
   localparam int SETUP_CYCLES  = 2;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SETUP = 2'b01,
      ST_ERASE = 2'b10
   } fre_state_e;
   // Key tracking
   typedef enum logic [1:0] {
      KEY_NONE = 2'b00,
      KEY_HALF = 2'b01,
      KEY_OPEN = 2'b10
   } fre_key_e;
endpackage
`default_nettype wire

// >>> verification/fre_chk.sv
// Checker: bus answer and erase timing of the row erase block
`default_nettype none
module fre_chk #(
   parameter int unsigned ERASE_CYC = 20
) (
   // Clock and reset
   input wire logic        CLK_IN,
   input wire logic        RST_B_IN,
   // Bus side
   input wire logic        WB_CYC_IN,
   input wire logic        WB_STB_IN,
   input wire logic        WB_WE_IN,
   input wire logic [5:0]  WB_ADR_IN,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic        WB_ACK_OUT,
   // Core and array side
   input wire logic        CORE_STALL_OUT,
   input wire logic        ERASE_BUSY_OUT,
   input wire logic [14:0] ERASE_ROW_ADDR_OUT
);
   logic [31:0] cnt_q;  // Stall cycles seen so far
   // Counter, since a repetition cannot span a long erase
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN || !CORE_STALL_OUT) cnt_q <= 32'h0000_0000;
      else cnt_q <= cnt_q + 32'h0000_0001;
   end
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // Two setup cycles with the core still running
   sequence setup_s;
      !CORE_STALL_OUT [*2];
   endsequence
   a_ack_answer: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
      |=> WB_ACK_OUT) else $error("bus request not answered");
   a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack longer than one cycle");
   a_high_zero: assert property (WB_ACK_OUT && !WB_WE_IN &&
      WB_ADR_IN[5:2] == 4'h1 |-> WB_DAT_OUT[7:6] == 2'b00)
      else $error("data high top bits not zero");
   a_setup_two: assert property ($rose(ERASE_BUSY_OUT)
      |-> setup_s ##1 CORE_STALL_OUT) else $error("setup not two cycles");
   a_stall_len: assert property ($fell(CORE_STALL_OUT)
      |-> cnt_q == ERASE_CYC) else $error("stall length wrong");
   a_stall_busy: assert property (CORE_STALL_OUT |-> ERASE_BUSY_OUT)
      else $error("stall outside busy");
   a_resume_end: assert property ($fell(CORE_STALL_OUT)
      |-> !ERASE_BUSY_OUT) else $error("busy after stall ends");
   a_row_align: assert property (ERASE_BUSY_OUT
      |-> ERASE_ROW_ADDR_OUT[4:0] == 5'h00) else $error("row not aligned");
   a_row_hold: assert property (ERASE_BUSY_OUT && $past(ERASE_BUSY_OUT)
      |-> $stable(ERASE_ROW_ADDR_OUT)) else $error("row moved in erase");
endmodule
bind fre_flash_row_erase_control fre_chk #(.ERASE_CYC(ERASE_CYC)) u_chk (
   .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .WB_CYC_IN(WB_CYC_IN),
   .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
   .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
   .CORE_STALL_OUT(CORE_STALL_OUT), .ERASE_BUSY_OUT(ERASE_BUSY_OUT),
   .ERASE_ROW_ADDR_OUT(ERASE_ROW_ADDR_OUT));
`default_nettype wire

// >>> verification/fre_flash_row_erase_control_tb.sv
// Testbench: register access, resets and row erase
`default_nettype none
module fre_flash_row_erase_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fre_pkg::*;
   localparam int unsigned ECYC = 20;  // Short erase keeps the run brief
   logic        clk = 1'b0, rst_b = 1'b0, por = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, stall, busy;
   logic [3:0]  sel = 4'hF;            // Only the low lane matters
   logic [5:0]  adr = 6'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic [14:0] row;
   logic [7:0]  r [3];                 // Random register contents
   logic [31:0] exp_q [$];             // Expected read data, oldest first
   int          fails = 0, compares = 0, cyc_n = 0, n, seed = 15648;
   always #2.5 clk = ~clk;
   fre_flash_row_erase_control #(.ERASE_CYC(ECYC)) dut (
      .CLK_IN(clk), .RST_B_IN(rst_b), .POR_IN(por), .WB_CYC_IN(cyc),
      .WB_STB_IN(stb), .WB_WE_IN(we), .WB_SEL_IN(sel), .WB_ADR_IN(adr),
      .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .CORE_STALL_OUT(stall), .ERASE_BUSY_OUT(busy),
      .ERASE_ROW_ADDR_OUT(row));
   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      compares++;
      if (got !== e) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, e);
      end
   endtask
   // One classic cycle, held until ack is seen
   task automatic wb(input logic w, input logic [3:0] i, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h00_0000, d};
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] i, input logic [7:0] e);
      exp_q.push_back({24'h00_0000, e});
      wb(1'b0, i, 8'h00);
   endtask
   task automatic rst(input logic p);
      por <= p;
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      por <= 1'b0;
      @(posedge clk);
   endtask
   task automatic start(input logic [7:0] k, input logic [7:0] c);
      wb(1'b1, OFS_KEY, KEY_FIRST);
      wb(1'b1, OFS_KEY, k);
      wb(1'b1, OFS_CTRL_ONE, c);
   endtask
   // Read data checked in the cycle ack stands
   always @(posedge clk) if (ack === 1'b1 && we === 1'b0)
      chk(rdat, exp_q.pop_front());
   // Hang guard
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n > 2000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      foreach (r[j]) r[j] = 8'($random(seed));
      rst(1'b1);
      rd(OFS_ADDR_LOW, 8'h00);
      wb(1'b1, OFS_DATA_LOW, r[0]);
      wb(1'b1, OFS_DATA_HIGH, r[1] | 8'hC0);
      wb(1'b1, OFS_ADDR_LOW, r[2]);
      rd(OFS_DATA_LOW, r[0]);
      rd(OFS_DATA_HIGH, r[1] & DATA_HIGH_MASK);
      rd(OFS_ADDR_LOW, r[2]);
      $display("test registers done");
      rst(1'b0);
      rd(OFS_ADDR_LOW, 8'h00);
      rd(OFS_DATA_LOW, r[0]);
      rd(OFS_DATA_HIGH, r[1] & DATA_HIGH_MASK);
      $display("test warm reset done");
      // Broken key, then config space selected: neither may start
      start(8'hA5, 8'h16);
      start(KEY_SECOND, 8'h56);
      repeat (3) @(posedge clk);
      chk(32'(busy), 32'h0000_0000);
      wb(1'b1, OFS_ADDR_HIGH, r[1]);
      wb(1'b1, OFS_ADDR_LOW, r[2]);
      start(KEY_SECOND, 8'h16);
      // No bus access during the two setup cycles
      while (stall !== 1'b1) @(posedge clk);
      chk(32'(row), 32'({r[1][6:0], r[2]} & ROW_MASK));
      // Bus still answers while the core is held; read takes 3 cycles
      rd(OFS_DATA_LOW, r[0]);
      for (n = 0; stall === 1'b1; n++) @(posedge clk);
      chk(n + 3, ECYC);
      chk(32'(busy), 32'h0000_0000);
      rd(OFS_CTRL_ONE, 8'h94);
      $display("test erase done");
      stop_test();
   end
endmodule
`default_nettype wire
